/* rtl/ers_map.vh */
// ers_map.vh: register offsets, bit positions, reset values and handshake
// codes of the endpoint 0 receive status tracker.
// assumes: included by bare name into the design and test files that use its macros.
//
// How it works
// - a valid OUT in the data stage with the expected PID that is answered with ACK flips the receive toggle bit
// - a successful SETUP forces the receive toggle bit to one
// - a successful SETUP sets the setup-seen flag, bit 6
// - software clears setup-seen by writing one; writing zero keeps it
// - setup-overwrite, bit 5, is high from SETUP start to SETUP end; read-only
// - setup-overwrite high means setup data is overwriting earlier OUT data
// - status-stage flag, bit 4, sets on status stage, clears at next SETUP start
// - stall bit 3 is set at OUT end when STALL was answered
// - a valid OUT with stall control set is answered with STALL
// - no-acknowledge bit 2 is set at OUT end when NACK was answered
// - a valid OUT with FIFO enable clear and stall control clear is answered with NACK
// - error bit 1 is set at end of an OUT that suffered any error
// - stall, nack and error bits are refreshed at the end of every OUT
// - ACK bit 0 sets on a good OUT with ACK sent and the expected PID, and raises the interrupt
// - the ACK bit clears by itself at the start of the next SETUP
// - FIFO enable control clears whenever the ACK bit becomes set
`ifndef ERS_MAP_VH
`define ERS_MAP_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define ERS_ADDR_W        5
`define ERS_OFF_STATUS    5'h00
`define ERS_OFF_CONTROL   5'h04
`define ERS_OFF_IRQ_STAT  5'h08
`define ERS_OFF_IRQ_MASK  5'h0C

// -----------------------------------------------------------------
// receive status bits
// -----------------------------------------------------------------
`define ERS_ST_TOGGLE     7
`define ERS_ST_SETUP      6
`define ERS_ST_OVERWRITE  5
`define ERS_ST_STATUS     4
`define ERS_ST_STALL      3
`define ERS_ST_NACK       2
`define ERS_ST_ERROR      1
`define ERS_ST_ACK        0
`define ERS_STATUS_RESET  8'h00

// -----------------------------------------------------------------
// receive control bits
// -----------------------------------------------------------------
`define ERS_CT_STALL      3
`define ERS_CT_FIFO_EN    1
`define ERS_CT_ENABLE     0
`define ERS_CONTROL_RESET 8'h00

// -----------------------------------------------------------------
// interrupt status and mask bits
// -----------------------------------------------------------------
`define ERS_IRQ_W         5
`define ERS_IRQ_ACK       0
`define ERS_IRQ_SETUP     1
`define ERS_IRQ_ERROR     2
`define ERS_IRQ_STALL     3
`define ERS_IRQ_NACK      4
`define ERS_IRQ_RESET     5'h00

// -----------------------------------------------------------------
// handshake codes
// -----------------------------------------------------------------
`define ERS_HS_NONE       2'h0
`define ERS_HS_ACK        2'h1
`define ERS_HS_NACK       2'h2
`define ERS_HS_STALL      2'h3

`endif

/* rtl/ers_sticky_bits.v */
// ers_sticky_bits.v: a vector of sticky flags, set by events, cleared by
// writing one.
// assumes: set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ers_sticky_bits #(
  parameter WIDTH = 5
) (
  input  wire             core_clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] set,
  input  wire [WIDTH-1:0] clear,
  output reg  [WIDTH-1:0] flags
);

  // -----------------------------------------------------------------
  // flag storage
  // -----------------------------------------------------------------
  // set is or-ed in after the clear so that an event in the clearing cycle survives
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flags <= {WIDTH{1'b0}};
    end else begin
      flags <= (flags & ~clear) | set;
    end
  end

endmodule

`default_nettype wire

/* rtl/ers_rx_status.v */
// ers_rx_status.v: receive status tracker of control endpoint 0 with its
// control bits, handshake choice, interrupt and Avalon-MM register slave.
// assumes: transaction event pulses come from the function control logic
// on core_clk, one cycle each, and never two kinds in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ers_map.vh"

module ers_rx_status (
  input  wire                   core_clk,
  input  wire                   resetn,
  // register slave
  input  wire [`ERS_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output reg  [31:0]            avs_readdata,
  output reg                    avs_waitrequest,
  // transaction events
  input  wire                   setup_begin,
  input  wire                   setup_end,
  input  wire                   setup_ok,
  input  wire                   out_end,
  input  wire                   out_error,
  input  wire                   out_data_stage,
  input  wire                   out_pid_data1,
  input  wire                   status_stage_seen,
  // handshake choice
  output reg                    hs_valid,
  output reg  [1:0]             hs_code,
  // control and state levels
  output reg                    rx_enable,
  output reg                    rx_fifo_accept_enable,
  output reg                    rx_stall_control,
  output reg                    rx_data_toggle,
  output reg                    setup_seen,
  output reg                    setup_overwrite_flag,
  output reg                    irq
);

  // -----------------------------------------------------------------
  // status flag storage
  // -----------------------------------------------------------------
  reg                  status_stage_flag;
  reg                  stall_seen;
  reg                  nack_seen;
  reg                  error_seen;
  reg                  ack_seen;
  reg  [`ERS_IRQ_W-1:0] irq_mask;
  wire [`ERS_IRQ_W-1:0] irq_flags;

  // next values
  reg                  next_toggle;
  reg                  next_setup_seen;
  reg                  next_overwrite;
  reg                  next_status_stage;
  reg                  next_stall_seen;
  reg                  next_nack_seen;
  reg                  next_error_seen;
  reg                  next_ack_seen;
  reg                  next_fifo_en;
  reg                  next_stall_ctl;
  reg  [1:0]           next_hs_code;

  // reset images, so the flops below follow the map rather than bare zeros
  localparam [7:0] ST_RST = `ERS_STATUS_RESET;
  localparam [7:0] CT_RST = `ERS_CONTROL_RESET;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  wire        bus_req;
  wire        wr_go;
  wire        sel_status;
  wire        sel_control;
  wire        sel_irq_stat;
  wire        sel_irq_mask;
  wire [7:0]  wr_byte;

  assign bus_req      = avs_read | avs_write;
  // a write lands only at the edge where waitrequest is seen low
  assign wr_go        = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign sel_status   = (avs_address == `ERS_OFF_STATUS);
  assign sel_control  = (avs_address == `ERS_OFF_CONTROL);
  assign sel_irq_stat = (avs_address == `ERS_OFF_IRQ_STAT);
  assign sel_irq_mask = (avs_address == `ERS_OFF_IRQ_MASK);
  assign wr_byte      = avs_writedata[7:0];

  // -----------------------------------------------------------------
  // transaction qualifiers
  // -----------------------------------------------------------------
  wire out_good;
  wire out_bad;
  wire pid_match;
  wire setup_good;
  wire ack_sent;
  wire ack_event;

  // an OUT that ended cleanly is a valid one; a bad one gets no handshake
  assign out_good   = out_end & ~out_error;
  assign out_bad    = out_end & out_error;
  assign pid_match  = (out_pid_data1 == rx_data_toggle);
  assign setup_good = setup_end & setup_ok;
  assign ack_sent   = out_good & (next_hs_code == `ERS_HS_ACK);
  // mismatched PID is still acked but the data is a repeat and is dropped
  assign ack_event  = ack_sent & pid_match;

  // -----------------------------------------------------------------
  // handshake choice
  // -----------------------------------------------------------------
  // stall takes precedence over the nack of a disabled FIFO
  always @* begin
    if (rx_stall_control) begin
      next_hs_code = `ERS_HS_STALL;
    end else if (!rx_fifo_accept_enable) begin
      next_hs_code = `ERS_HS_NACK;
    end else begin
      next_hs_code = `ERS_HS_ACK;
    end
  end

  // one handshake pulse per valid OUT
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hs_valid <= 1'b0;
      hs_code  <= `ERS_HS_NONE;
    end else begin
      hs_valid <= out_good;
      if (out_good) begin
        hs_code <= next_hs_code;
      end else begin
        hs_code <= `ERS_HS_NONE;
      end
    end
  end

  // -----------------------------------------------------------------
  // receive status next values
  // -----------------------------------------------------------------
  always @* begin
    next_toggle       = rx_data_toggle;
    next_setup_seen   = setup_seen;
    next_overwrite    = setup_overwrite_flag;
    next_status_stage = status_stage_flag;
    next_stall_seen   = stall_seen;
    next_nack_seen    = nack_seen;
    next_error_seen   = error_seen;
    next_ack_seen     = ack_seen;

    // software clears first so that hardware sets below win
    if (wr_go && sel_status) begin
      if (wr_byte[`ERS_ST_SETUP]) begin
        next_setup_seen = 1'b0;
      end
      if (wr_byte[`ERS_ST_ACK]) begin
        next_ack_seen = 1'b0;
      end
    end

    // setup start: fifo is being overwritten, old outcome is void
    if (setup_begin) begin
      next_overwrite    = 1'b1;
      next_status_stage = 1'b0;
      next_ack_seen     = 1'b0;
    end

    // setup end: overwrite window closes whatever the outcome
    if (setup_end) begin
      next_overwrite = 1'b0;
    end
    if (setup_good) begin
      next_setup_seen = 1'b1;
      next_toggle     = 1'b1;
    end

    // control transfer reached its status stage
    if (status_stage_seen) begin
      next_status_stage = 1'b1;
    end

    // every ended OUT rewrites the three outcome bits
    if (out_good) begin
      next_stall_seen = (next_hs_code == `ERS_HS_STALL);
      next_nack_seen  = (next_hs_code == `ERS_HS_NACK);
      next_error_seen = 1'b0;
    end
    if (out_bad) begin
      next_stall_seen = 1'b0;
      next_nack_seen  = 1'b0;
      next_error_seen = 1'b1;
    end

    // accepted data packet
    if (ack_event) begin
      next_ack_seen = 1'b1;
      if (out_data_stage) begin
        next_toggle = ~rx_data_toggle;
      end
    end
  end

  // status register flops
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_data_toggle       <= ST_RST[`ERS_ST_TOGGLE];
      setup_seen           <= ST_RST[`ERS_ST_SETUP];
      setup_overwrite_flag <= ST_RST[`ERS_ST_OVERWRITE];
      status_stage_flag    <= ST_RST[`ERS_ST_STATUS];
      stall_seen           <= ST_RST[`ERS_ST_STALL];
      nack_seen            <= ST_RST[`ERS_ST_NACK];
      error_seen           <= ST_RST[`ERS_ST_ERROR];
      ack_seen             <= ST_RST[`ERS_ST_ACK];
    end else begin
      rx_data_toggle       <= next_toggle;
      setup_seen           <= next_setup_seen;
      setup_overwrite_flag <= next_overwrite;
      status_stage_flag    <= next_status_stage;
      stall_seen           <= next_stall_seen;
      nack_seen            <= next_nack_seen;
      error_seen           <= next_error_seen;
      ack_seen             <= next_ack_seen;
    end
  end

  // -----------------------------------------------------------------
  // receive control register
  // -----------------------------------------------------------------
  // hardware clears win over a write in the same cycle, so the fifo
  // can never accept a second packet before software has seen the first
  always @* begin
    next_fifo_en   = rx_fifo_accept_enable;
    next_stall_ctl = rx_stall_control;
    if (wr_go && sel_control) begin
      next_fifo_en   = wr_byte[`ERS_CT_FIFO_EN];
      next_stall_ctl = wr_byte[`ERS_CT_STALL];
    end
    if (ack_event) begin
      next_fifo_en = 1'b0;
    end
    if (setup_good) begin
      next_fifo_en   = 1'b0;
      next_stall_ctl = 1'b0;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_enable             <= CT_RST[`ERS_CT_ENABLE];
      rx_fifo_accept_enable <= CT_RST[`ERS_CT_FIFO_EN];
      rx_stall_control      <= CT_RST[`ERS_CT_STALL];
    end else begin
      if (wr_go && sel_control) begin
        rx_enable <= wr_byte[`ERS_CT_ENABLE];
      end
      rx_fifo_accept_enable <= next_fifo_en;
      rx_stall_control      <= next_stall_ctl;
    end
  end

  // -----------------------------------------------------------------
  // interrupt
  // -----------------------------------------------------------------
  wire [`ERS_IRQ_W-1:0] irq_set;
  wire [`ERS_IRQ_W-1:0] irq_clear;

  assign irq_set[`ERS_IRQ_ACK]   = ack_event;
  assign irq_set[`ERS_IRQ_SETUP] = setup_good;
  assign irq_set[`ERS_IRQ_ERROR] = out_bad;
  assign irq_set[`ERS_IRQ_STALL] = out_good & (next_hs_code == `ERS_HS_STALL);
  assign irq_set[`ERS_IRQ_NACK]  = out_good & (next_hs_code == `ERS_HS_NACK);
  assign irq_clear = (wr_go && sel_irq_stat) ? wr_byte[`ERS_IRQ_W-1:0] : {`ERS_IRQ_W{1'b0}};

  ers_sticky_bits #(
    .WIDTH (`ERS_IRQ_W)
  ) u_irq_flags (
    .core_clk (core_clk),
    .resetn   (resetn),
    .set      (irq_set),
    .clear    (irq_clear),
    .flags    (irq_flags)
  );

  // mask register and registered level output
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= `ERS_IRQ_RESET;
      irq      <= 1'b0;
    end else begin
      if (wr_go && sel_irq_mask) begin
        irq_mask <= wr_byte[`ERS_IRQ_W-1:0];
      end
      irq <= |(irq_flags & irq_mask);
    end
  end

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  reg [7:0] rd_byte;

  // reads are pure: no flag changes on a read
  always @*  begin
    rd_byte = 8'h00;
    if (sel_status) begin
      rd_byte[`ERS_ST_TOGGLE]    = rx_data_toggle;
      rd_byte[`ERS_ST_SETUP]     = setup_seen;
      rd_byte[`ERS_ST_OVERWRITE] = setup_overwrite_flag;
      rd_byte[`ERS_ST_STATUS]    = status_stage_flag;
      rd_byte[`ERS_ST_STALL]     = stall_seen;
      rd_byte[`ERS_ST_NACK]      = nack_seen;
      rd_byte[`ERS_ST_ERROR]     = error_seen;
      rd_byte[`ERS_ST_ACK]       = ack_seen;
    end else if (sel_control) begin
      rd_byte[`ERS_CT_STALL]   = rx_stall_control;
      rd_byte[`ERS_CT_FIFO_EN] = rx_fifo_accept_enable;
      rd_byte[`ERS_CT_ENABLE]  = rx_enable;
    end else if (sel_irq_stat) begin
      rd_byte[`ERS_IRQ_W-1:0] = irq_flags;
    end else if (sel_irq_mask) begin
      rd_byte[`ERS_IRQ_W-1:0] = irq_mask;
    end
  end

  // -----------------------------------------------------------------
  // avalon handshake
  // -----------------------------------------------------------------
  // one wait state: data are captured while waitrequest is high and
  // stand at the edge where it is low; unmapped offsets read zero
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h000000, rd_byte};
      end
    end
  end

endmodule

`default_nettype wire

/* tb/ers_rx_status_asserts.sv */
// ers_rx_status_asserts.sv: concurrent checks on the receive status tracker.
// assumes: bound to ers_rx_status; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ers_map.vh"

module ers_rx_status_asserts (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       setup_begin,
  input wire logic       setup_end,
  input wire logic       setup_ok,
  input wire logic       out_end,
  input wire logic       out_error,
  input wire logic       out_data_stage,
  input wire logic       out_pid_data1,
  input wire logic       hs_valid,
  input wire logic [1:0] hs_code,
  input wire logic       rx_fifo_accept_enable,
  input wire logic       rx_stall_control,
  input wire logic       rx_data_toggle,
  input wire logic       setup_seen,
  input wire logic       setup_overwrite_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------
  // helper terms
  // ---------------------------------------------------------------
  // a valid OUT, and one whose PID is the expected one
  wire vout  = out_end & ~out_error;
  wire match = vout & (out_pid_data1 == rx_data_toggle);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_toggle_flip;
    match && out_data_stage && !rx_stall_control && rx_fifo_accept_enable |=> rx_data_toggle != $past(rx_data_toggle);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not flip on accepted packet");
  property p_toggle_hold;
    vout && !match |=> $stable(rx_data_toggle);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved on mismatched PID");
  property p_setup_done;
    setup_end && setup_ok |=> rx_data_toggle && setup_seen && !rx_fifo_accept_enable && !rx_stall_control;
  endproperty
  a_setup_done: assert property (p_setup_done) else $error("setup end state wrong");
  property p_overwrite_rise;
    setup_begin |=> setup_overwrite_flag;
  endproperty
  a_overwrite_rise: assert property (p_overwrite_rise) else $error("overwrite flag not raised");
  property p_overwrite_fall;
    setup_end |=> !setup_overwrite_flag;
  endproperty
  a_overwrite_fall: assert property (p_overwrite_fall) else $error("overwrite flag not dropped");
  property p_hs_stall;
    vout && rx_stall_control |=> hs_valid && hs_code == `ERS_HS_STALL;
  endproperty
  a_hs_stall: assert property (p_hs_stall) else $error("stall handshake missing");
  property p_hs_nack;
    vout && !rx_stall_control && !rx_fifo_accept_enable |=> hs_valid && hs_code == `ERS_HS_NACK;
  endproperty
  a_hs_nack: assert property (p_hs_nack) else $error("nack handshake missing");
  property p_hs_ack;
    match && !rx_stall_control && rx_fifo_accept_enable |=> hs_valid && hs_code == `ERS_HS_ACK && !rx_fifo_accept_enable;
  endproperty
  a_hs_ack: assert property (p_hs_ack) else $error("ack handshake or enable clear missing");
  property p_err_quiet;
    out_end && out_error |=> !hs_valid;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("handshake after errored OUT");
  property p_hs_cause;
    hs_valid |-> $past(vout);
  endproperty
  a_hs_cause: assert property (p_hs_cause) else $error("handshake without valid OUT");
endmodule

bind ers_rx_status ers_rx_status_asserts chk_u (.core_clk, .resetn, .setup_begin, .setup_end, .setup_ok, .out_end,
  .out_error, .out_data_stage, .out_pid_data1, .hs_valid, .hs_code, .rx_fifo_accept_enable, .rx_stall_control,
  .rx_data_toggle, .setup_seen, .setup_overwrite_flag);
`default_nettype wire

/* tb/ers_host_model.sv */
// ers_host_model.sv: far-side model of the host and function control events.
// assumes: the bench calls pulse after a clock edge; one event per call.
`timescale 1ns/1ps
`default_nettype none

module ers_host_model (
  input  wire logic core_clk,
  output var logic  setup_begin,
  output var logic  setup_end,
  output var logic  setup_ok,
  output var logic  out_end,
  output var logic  out_error,
  output var logic  out_data_stage,
  output var logic  out_pid_data1,
  output var logic  status_stage_seen
);
  // idle at time zero
  initial begin
    {setup_begin, setup_end, out_end, status_stage_seen} = 4'h0;
    {setup_ok, out_error, out_data_stage, out_pid_data1} = 4'h0;
  end

  // ---------------------------------------------------------------
  // one event: 0 setup start, 1 setup end, 2 OUT end, 3 status stage
  // ---------------------------------------------------------------
  // q = {error or ok, data stage, pid}; outside the pulse the qualifiers
  // show the inverse so a design that samples them late is caught
  task automatic pulse(input int kind, input logic [2:0] q);
    @(posedge core_clk);
    setup_begin       <= (kind == 0);
    setup_end         <= (kind == 1);
    out_end           <= (kind == 2);
    status_stage_seen <= (kind == 3);
    {setup_ok, out_data_stage, out_pid_data1} <= q;
    out_error         <= q[2];
    @(posedge core_clk);
    {setup_begin, setup_end, out_end, status_stage_seen} <= 4'h0;
    {setup_ok, out_data_stage, out_pid_data1} <= ~q;
    out_error         <= ~q[2];
  endtask
endmodule
`default_nettype wire

/* tb/ers_rx_status_bench.sv */
// ers_rx_status_bench.sv: self-checking bench of the receive status tracker.
// assumes: the host model drives events; this bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
`include "ers_map.vh"

module ers_rx_status_bench;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  wire  [31:0] avs_readdata;
  wire  [1:0]  hs_code;
  wire         avs_waitrequest, hs_valid, rx_enable, rx_fifo_accept_enable, rx_stall_control, irq;
  wire         rx_data_toggle, setup_seen, setup_overwrite_flag;
  wire         setup_begin, setup_end, setup_ok, out_end, out_error, out_data_stage, out_pid_data1;
  wire         status_stage_seen;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  integer      seed = 18;
  logic [31:0] rq[$];
  logic [1:0]  hq[$];
  logic        tg, ackx, pid;

  ers_rx_status dut_u (.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .setup_begin, .setup_end, .setup_ok, .out_end, .out_error, .out_data_stage,
    .out_pid_data1, .status_stage_seen, .hs_valid, .hs_code, .rx_enable, .rx_fifo_accept_enable,
    .rx_stall_control, .rx_data_toggle, .setup_seen, .setup_overwrite_flag, .irq);
  ers_host_model host_u (.core_clk, .setup_begin, .setup_end, .setup_ok, .out_end, .out_error, .out_data_stage,
    .out_pid_data1, .status_stage_seen);

  // ---------------------------------------------------------------
  // clock, timeout, report
  // ---------------------------------------------------------------
  always #50 core_clk = ~core_clk;
  // a hung handshake ends here rather than running forever
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    // a note never matched by a result means a missing answer
    chk("pending", 32'h0, hq.size() + rq.size());
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ---------------------------------------------------------------
  // bus master; waits for waitrequest low, no fixed latency assumed
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = $random(seed);
    @(posedge core_clk);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= ~w;
    avs_writedata  <= {r[31:8], d};
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  task automatic out(input logic [1:0] hs, input logic [2:0] q);
    hq.push_back(hs);
    host_u.pulse(2, q);
  endtask

  // ---------------------------------------------------------------
  // monitors: each result takes the oldest note of its kind
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) chk("readdata", rq.size() ? rq.pop_front() : 32'hx, avs_readdata);
    if (hs_valid === 1'b1) chk("hs_code", {30'h0, hq.size() ? hq.pop_front() : 2'bxx}, {30'h0, hs_code});
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rd(5'h00, 8'h00);
    rd(5'h04, 8'h00);
    rd(5'h08, 8'h00);
    rd(5'h0C, 8'h00);
    rd(5'h10, 8'h00);
    bus(1'b1, 5'h0C, 8'h03, 4'h1);
    host_u.pulse(0, 3'b000);
    rd(5'h00, 8'h20);
    host_u.pulse(1, 3'b100);
    rd(5'h00, 8'hC0);
    chk("irq", 32'h1, {31'h0, irq});
    // read-only bits, a zero write and a disabled byte lane all leave it
    bus(1'b1, 5'h00, 8'h3E, 4'h1);
    bus(1'b1, 5'h00, 8'h40, 4'h0);
    rd(5'h00, 8'hC0);
    bus(1'b1, 5'h00, 8'h40, 4'h1);
    rd(5'h00, 8'h80);
    bus(1'b1, 5'h08, 8'h02, 4'h1);
    bus(1'b1, 5'h04, 8'h01, 4'h1);
    out(`ERS_HS_NACK, 3'b011);
    rd(5'h00, 8'h84);
    bus(1'b1, 5'h04, 8'h03, 4'h1);
    out(`ERS_HS_ACK, 3'b011);
    rd(5'h00, 8'h01);
    rd(5'h04, 8'h01);
    chk("rx_enable", 32'h1, {31'h0, rx_enable});
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 5'h00, 8'h01, 4'h1);
    bus(1'b1, 5'h08, 8'h01, 4'h1);
    rd(5'h00, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    bus(1'b1, 5'h04, 8'h0B, 4'h1);
    out(`ERS_HS_STALL, 3'b010);
    rd(5'h00, 8'h08);
    host_u.pulse(2, 3'b111);
    rd(5'h00, 8'h02);
    // stall, nack and error events are masked, so the line stays low
    chk("irq", 32'h0, {31'h0, irq});
    tg = 1'b0;
    ackx = 1'b0;
    // random PIDs; the first one is forced to match
    for (int i = 0; i < 6; i++) begin
      pid = (i == 0) ? tg : 1'($random(seed));
      bus(1'b1, 5'h04, 8'h03, 4'h1);
      out(`ERS_HS_ACK, {2'b01, pid});
      ackx = ackx | (pid == tg);
      tg = (pid == tg) ? ~tg : tg;
      rd(5'h00, {tg, 6'h00, ackx});
    end
    host_u.pulse(3, 3'b000);
    rd(5'h00, {tg, 6'h08, ackx});
    host_u.pulse(0, 3'b000);
    rd(5'h00, {tg, 7'h20});
    host_u.pulse(1, 3'b000);
    rd(5'h00, {tg, 7'h00});
    repeat (4) @(posedge core_clk);
    conclude();
  end
endmodule
`default_nettype wire
